// ### rtl/odd_parity_gen.v
`timescale 1ns/1ps
`include "sec_cfg_defs.vh"

// ----------------------------------------
// Odd parity insertion on bit 0
// ----------------------------------------
module odd_parity_gen (
    // Word without parity
    input wire [15:0] word_in,
    // Word with parity in bit 0
    output wire [15:0] word_out
);
    // Bit 0 makes the count of ones over all 16 bits odd
    assign word_out = {word_in[15:1], ~(^word_in[15:1])};
endmodule

// ### rtl/sec_cfg_defs.vh
`ifndef SEC_CFG_DEFS_VH
`define SEC_CFG_DEFS_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define ADDR_CFG1 6'h14
`define ADDR_SECOND_CONFIG_UNLOCK 6'h15
`define CFG1_RESET 16'h0190
`define SECOND_CONFIG_UNLOCK_RESET 16'h0001

// ----------------------------------------
// First register fields
// ----------------------------------------
`define B_TIMEOUT_SEL 10
`define B_PULSE_FILTER 9
`define B_SAT_CLAMP 8
`define B_SHUTDOWN_ALARM_DIS 7
`define B_STAGE_MON_DIS 6
`define B_UNLOCK 5
`define B_BE_COMP 4
`define B_LAST_INVALID 1
`define B_PARITY 0
`define CFG1_WMASK 16'h07f0

// ----------------------------------------
// Second register fields
// ----------------------------------------
`define B_RES_HI 15
`define B_RES_LO 14
`define B_STATE_MON 13
`define B_NEG_OV_MODE 12
`define B_CLAMP_MODE 11
`define B_DIO_DIR 10
`define B_DELAY_HI 9
`define B_DELAY_LO 6
`define SECOND_CONFIG_UNLOCK_WMASK 16'hfff0

// ----------------------------------------
// Timing (ms) and cycle counts at 10 MHz
// ----------------------------------------
`define CLK_HZ 10000000
`define VM_TIMEOUT_REG_MS 15
`define VM_TIMEOUT_SLOW_MS 60
`define VM_TIMEOUT_REG_CYC (`VM_TIMEOUT_REG_MS * (`CLK_HZ / 1000))
`define VM_TIMEOUT_SLOW_CYC (`VM_TIMEOUT_SLOW_MS * (`CLK_HZ / 1000))

`endif

// ### rtl/secondary_config_registers.v
`timescale 1ns/1ps
`include "sec_cfg_defs.vh"


module secondary_config_registers (
    // Clock and reset
    input wire ref_clk_in,
    input wire srst_in,
    // Decoded serial message access
    input wire msg_valid_in,
    input wire msg_write_in,
    input wire [5:0] msg_addr_in,
    input wire [15:0] msg_wdata_in,
    input wire msg_discard_in,
    output reg [15:0] rd_data_out,
    // Device state inputs
    input wire operating_mode_two_in,
    input wire switch_off_cmd_in,
    input wire shutdown_tristate_evt_in,
    input wire neg_supply_ov_evt_in,
    input wire regular_off_seq_in,
    input wire safe_off_seq_in,
    input wire vm_active_in,
    input wire turn_on_cmd_in,
    // Configuration outputs
    output reg vm_timeout_out,
    output reg pulse_filter_enable_out,
    output reg sat_sense_clamp_out,
    output reg shutdown_class_a_evt_out,
    output reg output_stage_monitor_en_out,
    output reg base_emitter_comp_enable_out,
    output reg switch_state_monitor_enable_out,
    output reg neg_ov_class_b_out,
    output reg neg_ov_warning_out,
    output reg active_clamp_pin_out,
    output reg dio_output_enable_out,
    output reg two_level_on_active_out
);
    // ----------------------------------------
    // Register state
    // ----------------------------------------
    reg [15:0] cfg1_reg;
    reg [15:0] cfg1_next;
    reg [15:0] second_config_unlock_reg;
    reg [15:0] second_config_unlock_next;
    reg last_invalid_reg;
    reg operating_mode_two_prev_reg;
    reg [19:0] vm_cnt_reg;
    reg [3:0] on_cnt_reg;
    reg turn_on_prev_reg;
    reg [2:0] on_state_reg;
    reg [2:0] on_state_next;
    reg [3:0] on_cnt_next;
    reg on_active_next;
    reg [19:0] vm_cnt_next;
    reg vm_timeout_next;
    reg [15:0] rd_next;
    reg pulse_filter_next;
    reg sat_clamp_next;
    reg class_a_next;
    reg stage_mon_next;
    reg be_comp_next;
    reg state_mon_next;
    reg neg_ov_b_next;
    reg neg_ov_warn_next;
    reg clamp_pin_next;
    reg dio_oe_next;
    wire [31:0] vm_limit_wide;
    wire [15:0] cfg1_view;
    wire [15:0] second_config_unlock_view;
    wire [15:0] cfg1_par;
    wire [15:0] second_config_unlock_par;
    wire wr_ok;
    wire leave_operating_mode_two;
    wire [19:0] vm_limit;
    wire [3:0] on_delay;

    // One-hot states of the two-level turn-on sequence
    localparam [2:0] ON_IDLE = 3'b001;
    localparam [2:0] ON_PLATEAU = 3'b010;
    localparam [2:0] ON_FULL = 3'b100;

    assign wr_ok = msg_valid_in && msg_write_in && !msg_discard_in;
    assign leave_operating_mode_two = operating_mode_two_prev_reg && !operating_mode_two_in;
    assign on_delay = second_config_unlock_reg[`B_DELAY_HI:`B_DELAY_LO];
    // Slow timeout chosen by bit 10
    assign vm_limit_wide = cfg1_reg[`B_TIMEOUT_SEL] ? `VM_TIMEOUT_SLOW_CYC :
        `VM_TIMEOUT_REG_CYC;
    assign vm_limit = vm_limit_wide[19:0];

    // ----------------------------------------
    // Write path
    // ----------------------------------------
    always @* begin
        cfg1_next = cfg1_reg;
        second_config_unlock_next = second_config_unlock_reg;
        if (wr_ok && msg_addr_in == `ADDR_CFG1) begin
            cfg1_next = msg_wdata_in & `CFG1_WMASK;
        end
        // Locked writes are dropped silently
        if (wr_ok && msg_addr_in == `ADDR_SECOND_CONFIG_UNLOCK && cfg1_reg[`B_UNLOCK]) begin
            // Bits 15:14 stored as written; host keeps them zero
            second_config_unlock_next = (msg_wdata_in & `SECOND_CONFIG_UNLOCK_WMASK) | `SECOND_CONFIG_UNLOCK_RESET;
        end
        // Hardware clear wins over a same-cycle software set, for safety
        if (leave_operating_mode_two) begin
            cfg1_next[`B_UNLOCK] = 1'b0;
        end
    end

    // Parity only ever on read-back, storage keeps raw bits
    assign cfg1_view = {cfg1_reg[15:2], last_invalid_reg, 1'b0};
    assign second_config_unlock_view = {second_config_unlock_reg[15:2], last_invalid_reg, 1'b0};

    odd_parity_gen u_par1 (
        .word_in(cfg1_view),
        .word_out(cfg1_par)
    );

    odd_parity_gen u_par2 (
        .word_in(second_config_unlock_view),
        .word_out(second_config_unlock_par)
    );

    // Unknown addresses read as zero rather than aliasing a register
    always @* begin
        rd_next = rd_data_out;
        if (msg_valid_in) begin
            if (msg_addr_in == `ADDR_CFG1) begin
                rd_next = cfg1_par;
            end else if (msg_addr_in == `ADDR_SECOND_CONFIG_UNLOCK) begin
                rd_next = second_config_unlock_par;
            end else begin
                rd_next = 16'h0000;
            end
        end
    end

    // ----------------------------------------
    // Sequential state
    // ----------------------------------------
    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            cfg1_reg <= `CFG1_RESET & `CFG1_WMASK;
            second_config_unlock_reg <= `SECOND_CONFIG_UNLOCK_RESET;
            last_invalid_reg <= 1'b0;
            operating_mode_two_prev_reg <= 1'b0;
            rd_data_out <= 16'h0000;
        end else begin
            cfg1_reg <= cfg1_next;
            second_config_unlock_reg <= second_config_unlock_next;
            operating_mode_two_prev_reg <= operating_mode_two_in;
            rd_data_out <= rd_next;
            if (msg_valid_in) begin
                last_invalid_reg <= msg_discard_in;
            end
        end
    end

    // ----------------------------------------
    // Verification mode timeout
    // ----------------------------------------
    // Counter stops one below the limit; the flag stays until verification mode ends
    always @* begin
        vm_cnt_next = vm_cnt_reg;
        vm_timeout_next = vm_timeout_out;
        if (!vm_active_in) begin
            vm_cnt_next = 20'h00000;
            vm_timeout_next = 1'b0;
        end else if (vm_cnt_reg + 20'h00001 >= vm_limit) begin
            vm_timeout_next = 1'b1;
        end else begin
            vm_cnt_next = vm_cnt_reg + 20'h00001;
        end
    end

    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            vm_cnt_reg <= 20'h00000;
            vm_timeout_out <= 1'b0;
        end else begin
            vm_cnt_reg <= vm_cnt_next;
            vm_timeout_out <= vm_timeout_next;
        end
    end

    // ----------------------------------------
    // Two-level turn-on delay
    // ----------------------------------------
    // Plateau starts only on a rising turn-on command; a field written
    // while the command is held does not restart it mid-pulse
    always @* begin
        on_state_next = on_state_reg;
        on_cnt_next = on_cnt_reg;
        if (on_delay == 4'h0 || !turn_on_cmd_in) begin
            on_state_next = ON_IDLE;
            on_cnt_next = 4'h0;
        end else if (!turn_on_prev_reg) begin
            on_state_next = ON_PLATEAU;
            on_cnt_next = on_delay;
        end else begin
            case (on_state_reg)
                ON_IDLE: begin
                    on_state_next = ON_IDLE;
                end
                ON_PLATEAU: begin
                    // Plateau held for the programmed count of cycles
                    if (on_cnt_reg == 4'h1) begin
                        on_state_next = ON_FULL;
                    end
                    on_cnt_next = on_cnt_reg - 4'h1;
                end
                ON_FULL: begin
                    on_state_next = ON_FULL;
                end
                default: begin
                    on_state_next = ON_IDLE;
                    on_cnt_next = 4'h0;
                end
            endcase
        end
        on_active_next = (on_state_next == ON_PLATEAU);
    end

    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            on_state_reg <= ON_IDLE;
            on_cnt_reg <= 4'h0;
            turn_on_prev_reg <= 1'b0;
            two_level_on_active_out <= 1'b0;
        end else begin
            on_state_reg <= on_state_next;
            on_cnt_reg <= on_cnt_next;
            turn_on_prev_reg <= turn_on_cmd_in;
            two_level_on_active_out <= on_active_next;
        end
    end

    // ----------------------------------------
    // Configuration outputs
    // ----------------------------------------
    always @(posedge ref_clk_in) begin
        if (srst_in) begin
            pulse_filter_enable_out <= 1'b0;
            sat_sense_clamp_out <= 1'b0;
            shutdown_class_a_evt_out <= 1'b0;
            output_stage_monitor_en_out <= 1'b0;
            base_emitter_comp_enable_out <= 1'b0;
            switch_state_monitor_enable_out <= 1'b0;
            neg_ov_class_b_out <= 1'b0;
            neg_ov_warning_out <= 1'b0;
            active_clamp_pin_out <= 1'b0;
            dio_output_enable_out <= 1'b0;
        end else begin
            pulse_filter_enable_out <= pulse_filter_next;
            sat_sense_clamp_out <= sat_clamp_next;
            shutdown_class_a_evt_out <= class_a_next;
            output_stage_monitor_en_out <= stage_mon_next;
            base_emitter_comp_enable_out <= be_comp_next;
            switch_state_monitor_enable_out <= state_mon_next;
            neg_ov_class_b_out <= neg_ov_b_next;
            neg_ov_warning_out <= neg_ov_warn_next;
            active_clamp_pin_out <= clamp_pin_next;
            dio_output_enable_out <= dio_oe_next;
        end
    end

    // Next values kept apart so each output stays a plain flip-flop
    always @* begin
        pulse_filter_next = cfg1_reg[`B_PULSE_FILTER];
        sat_clamp_next = cfg1_reg[`B_SAT_CLAMP] && switch_off_cmd_in;
        class_a_next = shutdown_tristate_evt_in && !cfg1_reg[`B_SHUTDOWN_ALARM_DIS];
        stage_mon_next = !cfg1_reg[`B_STAGE_MON_DIS];
        be_comp_next = cfg1_reg[`B_BE_COMP];
        state_mon_next = second_config_unlock_reg[`B_STATE_MON];
        neg_ov_b_next = neg_supply_ov_evt_in && !second_config_unlock_reg[`B_NEG_OV_MODE];
        neg_ov_warn_next = neg_supply_ov_evt_in && second_config_unlock_reg[`B_NEG_OV_MODE];
        clamp_pin_next = safe_off_seq_in ||
            (regular_off_seq_in && !second_config_unlock_reg[`B_CLAMP_MODE]);
        dio_oe_next = second_config_unlock_reg[`B_DIO_DIR];
    end
endmodule

// ### sim/cfg_regs_monitor.sv
`timescale 1ns/1ps
module cfg_regs_monitor (
    // Clock, reset and messages
    input logic ref_clk_in, srst_in, msg_valid_in, msg_write_in, msg_discard_in,
    input logic [5:0] msg_addr_in,
    input logic [15:0] msg_wdata_in,
    input logic [15:0] rd_data_out,
    // Device state and configuration
    input logic switch_off_cmd_in, sat_sense_clamp_out,
    input logic shutdown_tristate_evt_in, shutdown_class_a_evt_out,
    input logic neg_supply_ov_evt_in, neg_ov_class_b_out, neg_ov_warning_out,
    input logic safe_off_seq_in, active_clamp_pin_out,
    input logic pulse_filter_enable_out, base_emitter_comp_enable_out,
    input logic output_stage_monitor_en_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (srst_in);
    sequence s_cfg1_wr;
        msg_valid_in && msg_write_in && !msg_discard_in && msg_addr_in == 6'h14;
    endsequence
    property p_parity;
        $past(msg_valid_in) |-> ^rd_data_out;
    endproperty
    a_parity: assert property (p_parity) else $error("even parity on read word");
    property p_pulse;
        s_cfg1_wr |-> ##2 pulse_filter_enable_out == $past(msg_wdata_in[9], 2);
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse filter wrong");
    property p_be_comp;
        s_cfg1_wr |-> ##2 base_emitter_comp_enable_out == $past(msg_wdata_in[4], 2);
    endproperty
    a_be_comp: assert property (p_be_comp) else $error("compensation wrong");
    property p_stage_mon;
        s_cfg1_wr |-> ##2 output_stage_monitor_en_out != $past(msg_wdata_in[6], 2);
    endproperty
    a_stage_mon: assert property (p_stage_mon) else $error("stage monitor wrong");
    property p_sat_clamp;
        sat_sense_clamp_out |-> $past(switch_off_cmd_in);
    endproperty
    a_sat_clamp: assert property (p_sat_clamp) else $error("clamp without off");
    property p_class_a;
        shutdown_class_a_evt_out |-> $past(shutdown_tristate_evt_in);
    endproperty
    a_class_a: assert property (p_class_a) else $error("class A without event");
    property p_neg_ov;
        neg_supply_ov_evt_in |=> neg_ov_class_b_out != neg_ov_warning_out;
    endproperty
    a_neg_ov: assert property (p_neg_ov) else $error("overvoltage class wrong");
    property p_clamp;
        safe_off_seq_in |=> active_clamp_pin_out;
    endproperty
    a_clamp: assert property (p_clamp) else $error("clamp pin idle in safe off");
endmodule

// ### sim/relay_model.sv
`timescale 1ns/1ps
module relay_model (
    input logic ref_clk_in,
    output logic valid_out = 1'b0,
    output logic write_out = 1'b0,
    output logic [5:0] addr_out = 6'h00,
    output logic [15:0] wdata_out = 16'h0000,
    output logic discard_out = 1'b0
);
    // Idle address and data lines show the inverse of the requested values, so stale data is never trusted
    task automatic xfer(input logic w, input logic [5:0] a, input logic [15:0] d,
                        input logic disc);
        @(posedge ref_clk_in);
        valid_out <= 1'b1;
        write_out <= w;
        addr_out <= a;
        discard_out <= disc;
        wdata_out <= (a == 6'h15) ? {2'b00, d[13:0]} : d;
        @(posedge ref_clk_in);
        valid_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask
endmodule

// ### sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic ref_clk_in = 1'b0, srst_in = 1'b1, msg_valid_in, msg_write_in, msg_discard_in;
    logic [5:0] msg_addr_in;
    logic [15:0] msg_wdata_in, rd_data_out;
    logic operating_mode_two_in = 0, switch_off_cmd_in = 0, shutdown_tristate_evt_in = 0;
    logic neg_supply_ov_evt_in = 0, regular_off_seq_in = 0, safe_off_seq_in = 0;
    logic vm_active_in = 0;
    logic turn_on_cmd_in = 0, vm_timeout_out, pulse_filter_enable_out, sat_sense_clamp_out;
    logic shutdown_class_a_evt_out, output_stage_monitor_en_out, base_emitter_comp_enable_out;
    logic switch_state_monitor_enable_out, neg_ov_class_b_out, neg_ov_warning_out;
    logic active_clamp_pin_out, dio_output_enable_out, two_level_on_active_out;
    int bad_count = 0, checks_done = 0, cycles = 0;
    always #50 ref_clk_in = ~ref_clk_in;
    relay_model u_relay_model (.ref_clk_in, .valid_out(msg_valid_in), .write_out(msg_write_in),
        .addr_out(msg_addr_in), .wdata_out(msg_wdata_in), .discard_out(msg_discard_in));
    secondary_config_registers u_secondary_config_registers (.ref_clk_in, .srst_in,
        .msg_valid_in, .msg_write_in, .msg_addr_in, .msg_wdata_in, .msg_discard_in,
        .rd_data_out, .operating_mode_two_in, .switch_off_cmd_in, .shutdown_tristate_evt_in,
        .neg_supply_ov_evt_in, .regular_off_seq_in, .safe_off_seq_in, .vm_active_in,
        .turn_on_cmd_in, .vm_timeout_out, .pulse_filter_enable_out, .sat_sense_clamp_out,
        .shutdown_class_a_evt_out, .output_stage_monitor_en_out, .base_emitter_comp_enable_out,
        .switch_state_monitor_enable_out, .neg_ov_class_b_out, .neg_ov_warning_out,
        .active_clamp_pin_out, .dio_output_enable_out, .two_level_on_active_out);
    task automatic tally_and_finish();
        if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        u_relay_model.xfer(1'b1, a, d, 1'b0);
    endtask
    task automatic rd(input logic [5:0] a, input logic [15:0] exp);
        u_relay_model.xfer(1'b0, a, 16'h0000, 1'b0);
        @(posedge ref_clk_in);
        chk("rd_data_out", exp, rd_data_out);
    endtask
    task automatic settle();
        repeat (3) @(posedge ref_clk_in);
    endtask
    task automatic tl_count(input logic [15:0] exp);
        logic [15:0] n;
        n = 16'h0000;
        settle();
        turn_on_cmd_in <= 1'b1;
        repeat (30) begin
            @(posedge ref_clk_in);
            n = n + two_level_on_active_out;
        end
        turn_on_cmd_in <= 1'b0;
        chk("two_level_on_active_out", exp, n);
    endtask
    task automatic t_fields();
        wr(6'h14, 16'h0750);
        switch_off_cmd_in <= 1'b1;
        shutdown_tristate_evt_in <= 1'b1;
        settle();
        chk("pulse_filter_enable_out", 1, pulse_filter_enable_out);
        chk("base_emitter_comp_enable_out", 1, base_emitter_comp_enable_out);
        chk("output_stage_monitor_en_out", 0, output_stage_monitor_en_out);
        chk("sat_sense_clamp_out", 1, sat_sense_clamp_out);
        chk("shutdown_class_a_evt_out", 1, shutdown_class_a_evt_out);
        wr(6'h14, 16'h0080);
        settle();
        chk("shutdown_class_a_evt_out", 0, shutdown_class_a_evt_out);
        chk("sat_sense_clamp_out", 0, sat_sense_clamp_out);
        chk("output_stage_monitor_en_out", 1, output_stage_monitor_en_out);
        switch_off_cmd_in <= 1'b0;
        shutdown_tristate_evt_in <= 1'b0;
    endtask
    task automatic t_lock();
        wr(6'h15, 16'h3fc0);
        rd(6'h15, 16'h0001);
        wr(6'h14, 16'h0020);
        wr(6'h15, 16'h3c00);
        rd(6'h15, 16'h3c01);
        neg_supply_ov_evt_in <= 1'b1;
        regular_off_seq_in <= 1'b1;
        settle();
        chk("switch_state_monitor_enable_out", 1, switch_state_monitor_enable_out);
        chk("dio_output_enable_out", 1, dio_output_enable_out);
        chk("neg_ov_warning_out", 1, neg_ov_warning_out);
        chk("neg_ov_class_b_out", 0, neg_ov_class_b_out);
        chk("active_clamp_pin_out", 0, active_clamp_pin_out);
        neg_supply_ov_evt_in <= 1'b0;
        regular_off_seq_in <= 1'b0;
        safe_off_seq_in <= 1'b1;
        settle();
        chk("active_clamp_pin_out", 1, active_clamp_pin_out);
        safe_off_seq_in <= 1'b0;
    endtask
    task automatic t_mode_exit();
        operating_mode_two_in <= 1'b1;
        settle();
        operating_mode_two_in <= 1'b0;
        settle();
        wr(6'h15, 16'h0000);
        rd(6'h15, 16'h3c01);
        rd(6'h14, 16'h0001);
    endtask
    task automatic t_discard();
        u_relay_model.xfer(1'b1, 6'h14, 16'h0020, 1'b1);
        rd(6'h14, 16'h0002);
        rd(6'h14, 16'h0001);
    endtask
    task automatic t_two_level();
        // Delay of 0xa in bits 9:6 should give ten plateau cycles
        wr(6'h14, 16'h0020);
        wr(6'h15, 16'h0280);
        neg_supply_ov_evt_in <= 1'b1;
        settle();
        chk("neg_ov_class_b_out", 1, neg_ov_class_b_out);
        chk("neg_ov_warning_out", 0, neg_ov_warning_out);
        chk("dio_output_enable_out", 0, dio_output_enable_out);
        chk("switch_state_monitor_enable_out", 0, switch_state_monitor_enable_out);
        neg_supply_ov_evt_in <= 1'b0;
        tl_count(16'h000a);
        wr(6'h15, 16'h0000);
        tl_count(16'h0000);
    endtask
    task automatic t_vm_timeout();
        // The full timeout is far beyond the run; only an early flag is caught
        vm_active_in <= 1'b1;
        repeat (200) @(posedge ref_clk_in);
        chk("vm_timeout_out", 0, vm_timeout_out);
        vm_active_in <= 1'b0;
    endtask
    initial begin
        repeat (2) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        rd(6'h14, 16'h0190);
        rd(6'h15, 16'h0001);
        t_fields();
        t_lock();
        t_mode_exit();
        t_discard();
        t_two_level();
        t_vm_timeout();
        tally_and_finish();
    end
endmodule
bind secondary_config_registers cfg_regs_monitor u_mon (.ref_clk_in, .srst_in, .msg_valid_in,
    .msg_write_in, .msg_discard_in, .msg_addr_in, .msg_wdata_in, .rd_data_out,
    .switch_off_cmd_in, .sat_sense_clamp_out, .shutdown_tristate_evt_in,
    .shutdown_class_a_evt_out, .neg_supply_ov_evt_in, .neg_ov_class_b_out, .neg_ov_warning_out,
    .safe_off_seq_in, .active_clamp_pin_out, .pulse_filter_enable_out,
    .base_emitter_comp_enable_out, .output_stage_monitor_en_out);
